/* File: dv/rcrb_host_model.sv */
// Host model issuing serial register commands
`timescale 1ns/1ps
module rcrb_host_model
(
  output logic spiClk, // Serial clock, idles low
  output logic spiCsN, // Frame select
  output logic spiMosi, // Serial data out
  input wire logic spiMisoOut, // Serial data in
  input wire logic spiMisoOe // Drive enable of the bank
);
  import rcrb_pkg::*;
  rcrb_byte_t rdData;
  event done;
  initial
  begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // ---------------------------------------------
  // One register per frame, 48 ns bit time
  // ---------------------------------------------
  // command then data, test space untouched
  task automatic xfer(input logic wr, input rcrb_addr_t a, input rcrb_byte_t d);
    logic [15:0] tx;
    tx = {2'b00, wr, a, d};
    if (wr && a inside {[5'h18:5'h1B]})
      return;
    #7.1;
    spiCsN = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spiMosi = tx[i];
      #24 spiClk = 1'b1;
      if (i < 8)
        rdData[i] = spiMisoOe ? spiMisoOut : 1'bx;
      #24 spiClk = 1'b0;
    end
    #24 spiCsN = 1'b1;
    if (!wr)
      ->done;
    #48;
  endtask
endmodule

/* File: dv/rcrb_monitor.sv */
// Port checker for the radio configuration register bank
`timescale 1ns/1ps
module rcrb_monitor
#(
  parameter int unsigned RETRY_DELAY_STEP = 4 // Cycles per delay step
)
(
  input wire logic clk, // System clock
  input wire logic reset, // Sync reset
  input wire logic spiCsN, // Frame select
  input wire logic spiMisoOe, // Data drive enable
  input wire logic receiveReadyEvent, // Event pulse
  input wire logic transmitDoneEvent, // Event pulse
  input wire logic retryLimitEvent, // Event pulse
  input wire logic radioIrqN, // Interrupt line
  input wire logic receiveReadyFlag, // Sticky flag
  input wire logic transmitDoneFlag, // Sticky flag
  input wire logic retryLimitFlag, // Sticky flag
  input wire logic crcEnable, // Effective CRC enable
  input wire logic [rcrb_pkg::PIPE_COUNT-1:0] autoackPipeEnables, // Auto-ack
  input wire logic [2:0] addrWidthBytes, // Address bytes
  input wire logic [rcrb_pkg::MAX_ADDR_BYTES-1:0] addrByteUsed, // Bytes used
  input wire logic [rcrb_pkg::RETRY_DELAY_W-1:0] retryDelayCycles, // Wait
  input wire logic [3:0] retryCountField, // Retry count
  input wire logic retransmitEnable // Retries allowed
);
  import rcrb_pkg::*;
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_flag_up(f);
    ##1 f;
  endsequence
  a_reset_values: assert property ($fell(reset) |-> radioIrqN && crcEnable &&
    autoackPipeEnables == 6'h3F && addrWidthBytes == 3'h5 && retryCountField == 4'h3 &&
    retryDelayCycles == RETRY_DELAY_STEP) else $error("reset values wrong");
  a_rx_flag_set: assert property (receiveReadyEvent |-> s_flag_up(receiveReadyFlag))
    else $error("receive flag not set");
  a_tx_flag_set: assert property (transmitDoneEvent |-> s_flag_up(transmitDoneFlag))
    else $error("transmit flag not set");
  a_rt_flag_set: assert property (retryLimitEvent |-> s_flag_up(retryLimitFlag))
    else $error("retry flag not set");
  a_irq_idle_high: assert property (!(receiveReadyFlag || transmitDoneFlag ||
    retryLimitFlag) |-> radioIrqN) else $error("interrupt without flag");
  a_crc_forced_on: assert property (|autoackPipeEnables |-> crcEnable)
    else $error("crc not forced");
  a_width_bytes_map: assert property ((addrWidthBytes == 3'h3 && addrByteUsed == 5'h07) ||
    (addrWidthBytes == 3'h4 && addrByteUsed == 5'h0F) ||
    (addrWidthBytes == 3'h5 && addrByteUsed == 5'h1F) ||
    (addrWidthBytes == 3'h0 && addrByteUsed == 5'h00)) else $error("width map wrong");
  a_delay_step_range: assert property (retryDelayCycles % RETRY_DELAY_STEP == 0 &&
    retryDelayCycles >= RETRY_DELAY_STEP && retryDelayCycles <= 16 * RETRY_DELAY_STEP)
    else $error("delay out of range");
  a_retry_count_gate: assert property (retransmitEnable == (retryCountField != 4'h0))
    else $error("retry enable wrong");
  a_drive_enable_cs: assert property (spiMisoOe == !spiCsN)
    else $error("drive enable wrong");
endmodule
bind rcrb_radio_config_register_bank rcrb_monitor #(.RETRY_DELAY_STEP(RETRY_DELAY_STEP))
  i_rcrb_monitor (.clk, .reset, .spiCsN, .spiMisoOe, .receiveReadyEvent, .transmitDoneEvent,
  .retryLimitEvent, .radioIrqN, .receiveReadyFlag, .transmitDoneFlag, .retryLimitFlag,
  .crcEnable, .autoackPipeEnables, .addrWidthBytes, .addrByteUsed, .retryDelayCycles,
  .retryCountField, .retransmitEnable);

/* File: dv/rcrb_radio_config_register_bank_test.sv */
// Self-checking bench for the radio configuration register bank
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module rcrb_radio_config_register_bank_test;
  import rcrb_pkg::*;
  localparam int unsigned STEP = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] evs = 3'h0;
  logic spiClk, spiCsN, spiMosi, spiMisoOut, spiMisoOe, radioIrqN, crcEnable, retransmitEnable;
  logic receiveReadyFlag, transmitDoneFlag, retryLimitFlag, powerOnBit, receiverRoleSelect;
  logic crcLengthSelect;
  logic [5:0] autoackPipeEnables, rxPipeEnables;
  logic [2:0] addrWidthBytes;
  logic [4:0] addrByteUsed;
  logic [19:0] retryDelayCycles;
  logic [3:0] retryCountField;
  int fails = 0;
  int nCompared = 0;
  int seed = 38;
  rcrb_byte_t expQ[$];
  rcrb_byte_t sh[5];
  rcrb_byte_t d;
  rcrb_byte_t expV;
  rcrb_byte_t rst[5] = '{8'h08, 8'h3F, 8'h03, 8'h03, 8'h03};
  rcrb_byte_t wm[5] = '{CONTROL_WMASK, PIPE_WMASK, PIPE_WMASK, ADDR_WIDTH_WMASK,
    RETRANSMIT_WMASK};
  rcrb_radio_config_register_bank #(.RETRY_DELAY_STEP(STEP)) i_rcrb_radio_config_register_bank
    (.clk, .reset, .spiClk, .spiCsN, .spiMosi, .spiMisoOut, .spiMisoOe,
    .receiveReadyEvent(evs[2]), .transmitDoneEvent(evs[1]), .retryLimitEvent(evs[0]),
    .radioIrqN, .receiveReadyFlag, .transmitDoneFlag, .retryLimitFlag, .powerOnBit,
    .receiverRoleSelect, .crcEnable, .crcLengthSelect, .autoackPipeEnables, .rxPipeEnables,
    .addrWidthBytes, .addrByteUsed, .retryDelayCycles, .retryCountField, .retransmitEnable);
  rcrb_host_model i_rcrb_host_model (.spiClk, .spiCsN, .spiMosi, .spiMisoOut, .spiMisoOe);
  always #2.5 clk = ~clk;
  always @(i_rcrb_host_model.done)
  begin
    expV = expQ.pop_front();
    `CHK(i_rcrb_host_model.rdData, expV)
  end
  task automatic wr(input rcrb_addr_t a, input rcrb_byte_t v);
    i_rcrb_host_model.xfer(1'b1, a, v);
    repeat (10) @(posedge clk);
  endtask
  task automatic rd(input rcrb_addr_t a, input rcrb_byte_t e);
    expQ.push_back(e);
    i_rcrb_host_model.xfer(1'b0, a, 8'h00);
  endtask
  // Events are one-cycle pulses in the clk domain
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    evs <= v;
    @(posedge clk);
    evs <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    for (int a = 0; a < 5; a++)
      rd(5'(a), rst[a]);
    rd(ADDR_STATUS, 8'h00);
    wr(5'h10, 8'hFF);
    rd(5'h10, 8'h00);
    sh = rst;
    for (int r = 0; r < 4; r++)
    begin
      for (int a = 4; a >= 0; a--)
      begin
        d = 8'($random(seed));
        // host never programs width code 00
        if (a == 3 && d[1:0] == 2'h0)
          d[0] = 1'b1;
        wr(5'(a), d);
        sh[a] = d & wm[a];
        rd(5'(a), a == 0 && |sh[1] ? sh[0] | 8'h08 : sh[a]);
      end
      `CHK(powerOnBit, sh[0][1])
      `CHK(receiverRoleSelect, sh[0][0])
      `CHK(crcLengthSelect, sh[0][2])
      `CHK(autoackPipeEnables, sh[1][5:0])
      `CHK(rxPipeEnables, sh[2][5:0])
      `CHK(retryCountField, sh[4][3:0])
    end
    wr(ADDR_AUTOACK_PIPE_ENABLES, 8'h00);
    wr(ADDR_RADIO_CONTROL, 8'h00);
    `CHK(crcEnable, 1'b0)
    wr(ADDR_AUTOACK_PIPE_ENABLES, 8'h20);
    rd(ADDR_RADIO_CONTROL, 8'h08);
    for (int c = 1; c < 4; c++)
    begin
      wr(ADDR_ADDRESS_WIDTH_SETUP, 8'(c));
      `CHK(addrWidthBytes, 3'(c + 2))
    end
    wr(ADDR_RETRANSMIT_SETUP, 8'hF0);
    `CHK(retryDelayCycles, 20'(16 * STEP))
    `CHK(retransmitEnable, 1'b0)
    for (int k = 0; k < 3; k++)
    begin
      pulse(3'(1 << k));
      `CHK(radioIrqN, 1'b0)
      rd(ADDR_STATUS, 8'(8'h10 << k));
      wr(ADDR_STATUS, 8'(8'h10 << k));
      `CHK(radioIrqN, 1'b1)
    end
    // Masked sources set their flags but keep the line quiet
    wr(ADDR_RADIO_CONTROL, 8'h70);
    pulse(3'h7);
    `CHK(radioIrqN, 1'b1)
    rd(ADDR_STATUS, 8'h70);
    wr(ADDR_STATUS, 8'h70);
    rd(ADDR_STATUS, 8'h00);
    tally_and_finish();
  end
  initial
  begin
    #150us;
    fails++;
    tally_and_finish();
  end
endmodule

/* File: src/rcrb_pkg.sv */
// Shared constants and types for the radio configuration register bank
package rcrb_pkg;

  // ---------------------------------------------------------------
  // Widths and storage shape
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIPE_COUNT = 6;
  localparam int unsigned SHADOW_DEPTH = 8;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned MAX_ADDR_BYTES = 5;
  localparam int unsigned RETRY_DELAY_W = 20;

  typedef logic [DATA_W-1:0] rcrb_byte_t;
  typedef logic [ADDR_W-1:0] rcrb_addr_t;
  typedef logic [SHADOW_DEPTH-1:0][DATA_W-1:0] rcrb_shadow_t;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam rcrb_addr_t ADDR_RADIO_CONTROL = 5'h00;
  localparam rcrb_addr_t ADDR_AUTOACK_PIPE_ENABLES = 5'h01;
  localparam rcrb_addr_t ADDR_RX_PIPE_ENABLES = 5'h02;
  localparam rcrb_addr_t ADDR_ADDRESS_WIDTH_SETUP = 5'h03;
  localparam rcrb_addr_t ADDR_RETRANSMIT_SETUP = 5'h04;
  localparam rcrb_addr_t ADDR_STATUS = 5'h07;

  // ---------------------------------------------------------------
  // Serial command opcodes (top three bits of the command byte)
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_OP_READ = 3'h0;
  localparam logic [2:0] CMD_OP_WRITE = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned MASK_RECEIVE_READY_BIT = 6;
  localparam int unsigned MASK_TRANSMIT_DONE_BIT = 5;
  localparam int unsigned MASK_RETRY_LIMIT_BIT = 4;
  localparam int unsigned CRC_ENABLE_BIT = 3;
  localparam int unsigned CRC_LENGTH_BIT = 2;
  localparam int unsigned POWER_ON_BIT = 1;
  localparam int unsigned RECEIVER_ROLE_BIT = 0;
  localparam int unsigned RECEIVE_READY_FLAG_BIT = 6;
  localparam int unsigned TRANSMIT_DONE_FLAG_BIT = 5;
  localparam int unsigned RETRY_LIMIT_FLAG_BIT = 4;
  localparam int unsigned RETRY_DELAY_MSB = 7;
  localparam int unsigned RETRY_DELAY_LSB = 4;
  localparam int unsigned RETRY_COUNT_MSB = 3;
  localparam int unsigned RETRY_COUNT_LSB = 0;

  // ---------------------------------------------------------------
  // Writable bits and reset values
  // ---------------------------------------------------------------
  localparam rcrb_byte_t CONTROL_WMASK = 8'h7F;
  localparam rcrb_byte_t PIPE_WMASK = 8'h3F;
  localparam rcrb_byte_t ADDR_WIDTH_WMASK = 8'h03;
  localparam rcrb_byte_t RETRANSMIT_WMASK = 8'hFF;
  localparam rcrb_byte_t CONTROL_RESET = 8'h08;
  localparam rcrb_byte_t AUTOACK_RESET = 8'h3F;
  localparam rcrb_byte_t RX_PIPE_RESET = 8'h03;
  localparam rcrb_byte_t ADDR_WIDTH_RESET = 8'h03;
  localparam rcrb_byte_t RETRANSMIT_RESET = 8'h03;

  // ---------------------------------------------------------------
  // Address width codes
  // ---------------------------------------------------------------
  localparam logic [1:0] AW_CODE_3_BYTES = 2'h1;
  localparam logic [1:0] AW_CODE_4_BYTES = 2'h2;
  localparam logic [1:0] AW_CODE_5_BYTES = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned RETRY_DELAY_STEP_US = 250;
  localparam int unsigned RETRY_DELAY_STEP_CYCLES = RETRY_DELAY_STEP_US * CLK_FREQ_MHZ;

endpackage

/* File: src/rcrb_radio_config_register_bank.sv */
// Radio configuration register bank: registers, flags and interrupt line
//
// Summary of operation
// - Host reads and writes registers over serial.
// - Undefined bits always read back zero.
// - Three masks keep flags off interrupt line.
// - CRC forced on by any auto-acknowledge pipe.
// - Power-on bit and receiver role bit.
// - Six auto-acknowledge enables, all reset set.
// - Six receive pipe enables, pipes 0,1 set.
// - Address width code 3/4/5 bytes, reset 5.
// - Shorter addresses use least significant bytes.
// - Retry delay is 250 us times (code+1).
// - Retry count up to 15, zero disables.
// - Unmasked flag asserts line; write-1 clears.
`timescale 1ns/1ps
module rcrb_radio_config_register_bank
#(
  parameter int unsigned RETRY_DELAY_STEP = rcrb_pkg::RETRY_DELAY_STEP_CYCLES // Cycles per step
)
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic spiClk, // Host serial clock
  input wire logic spiCsN, // Host frame select, active low
  input wire logic spiMosi, // Host serial data in
  output logic spiMisoOut, // Serial data out
  output logic spiMisoOe, // Serial data drive enable
  input wire logic receiveReadyEvent, // Pulse: payload received
  input wire logic transmitDoneEvent, // Pulse: packet sent
  input wire logic retryLimitEvent, // Pulse: retries exhausted
  output logic radioIrqN, // Interrupt line, active low
  output logic receiveReadyFlag, // Sticky receive flag
  output logic transmitDoneFlag, // Sticky transmit flag
  output logic retryLimitFlag, // Sticky retry flag
  output logic powerOnBit, // Radio powered up
  output logic receiverRoleSelect, // 1 receiver, 0 transmitter
  output logic crcEnable, // Effective CRC enable
  output logic crcLengthSelect, // 0 one byte, 1 two bytes
  output logic [rcrb_pkg::PIPE_COUNT-1:0] autoackPipeEnables, // Per-pipe auto-ack
  output logic [rcrb_pkg::PIPE_COUNT-1:0] rxPipeEnables, // Per-pipe receive enable
  output logic [2:0] addrWidthBytes, // Address bytes, 0 if illegal
  output logic [rcrb_pkg::MAX_ADDR_BYTES-1:0] addrByteUsed, // Used address bytes, LSB first
  output logic [rcrb_pkg::RETRY_DELAY_W-1:0] retryDelayCycles, // Wait between tries
  output logic [3:0] retryCountField, // Maximum retries
  output logic retransmitEnable // Retries allowed
);
  import rcrb_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Keep unwritable bits
  function automatic rcrb_byte_t mergeWrite(input rcrb_byte_t current, input rcrb_byte_t data,
                                            input rcrb_byte_t writable);
    mergeWrite = (current & ~writable) | (data & writable);
  endfunction

  // Code 00 gives zero
  function automatic logic [2:0] widthBytes(input logic [1:0] code);
    logic [2:0] bytes;
    bytes = 3'h0;
    unique case (code)
      AW_CODE_3_BYTES: bytes = 3'h3;
      AW_CODE_4_BYTES: bytes = 3'h4;
      AW_CODE_5_BYTES: bytes = 3'h5;
      default: bytes = 3'h0;
    endcase
    widthBytes = bytes;
  endfunction

  // Lane i: byte i used
  function automatic logic [MAX_ADDR_BYTES-1:0] usedBytes(input logic [2:0] bytes);
    logic [MAX_ADDR_BYTES-1:0] lanes;
    lanes = '0;
    for (int i = 0; i < MAX_ADDR_BYTES; i++)
      lanes[i] = (3'(i) < bytes);
    usedBytes = lanes;
  endfunction

  // Cut to output width
  function automatic logic [RETRY_DELAY_W-1:0] delayCycles(input logic [3:0] code);
    logic [RETRY_DELAY_W-1:0] step;
    step = RETRY_DELAY_W'(RETRY_DELAY_STEP);
    delayCycles = RETRY_DELAY_W'((RETRY_DELAY_W'(code) + 1'b1) * step);
  endfunction

  // ---------------------------------------------------------------
  // Serial link end
  // ---------------------------------------------------------------
  // Resets at frame end
  rcrb_spi_if spiBus ();

  rcrb_spi_link link
  (
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut),
    .spiMisoOe(spiMisoOe),
    .bus(spiBus.link)
  );

  // ---------------------------------------------------------------
  // Crossing from the serial clock
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] csSync;
  logic [SYNC_STAGES-1:0] writeSync;
  logic frameIdle;
  logic writeLevel;

  // Last two stages agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      csSync <= '1;
      writeSync <= '0;
    end
    else
    begin
      csSync <= {csSync[SYNC_STAGES-2:0], spiCsN};
      writeSync <= {writeSync[SYNC_STAGES-2:0], spiBus.writeValid};
    end
  end

  wire csAgree = (csSync[1] == csSync[2]);
  wire writeAgree = (writeSync[1] == writeSync[2]);
  // Once per frame
  wire writeFire = writeAgree && writeSync[2] && !writeLevel;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      frameIdle <= 1'b1;
      writeLevel <= 1'b0;
    end
    else
    begin
      if (csAgree)
        frameIdle <= csSync[2];
      if (writeAgree)
        writeLevel <= writeSync[2];
    end
  end

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  // test addresses fall through decode; no write lands there
  wire rcrb_addr_t hostAddr = spiBus.writeAddr;
  wire rcrb_byte_t hostData = spiBus.writeData;
  wire writeControl = writeFire && (hostAddr == ADDR_RADIO_CONTROL);
  wire writeAutoack = writeFire && (hostAddr == ADDR_AUTOACK_PIPE_ENABLES);
  wire writeRxPipes = writeFire && (hostAddr == ADDR_RX_PIPE_ENABLES);
  wire writeAddrWidth = writeFire && (hostAddr == ADDR_ADDRESS_WIDTH_SETUP);
  wire writeRetransmit = writeFire && (hostAddr == ADDR_RETRANSMIT_SETUP);

  // Clears flags only
  wire writeStatus = writeFire && (hostAddr == ADDR_STATUS);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Stored registers
  rcrb_byte_t radioControl;
  rcrb_byte_t autoackPipeReg;
  rcrb_byte_t rxPipeReg;
  rcrb_byte_t addressWidthSetup;
  rcrb_byte_t retransmitSetup;

  // reserved bits are never stored, so they read as zero
  // masks, power and role live in the control byte
  wire rcrb_byte_t next_radioControl =
    writeControl ? mergeWrite(radioControl, hostData, CONTROL_WMASK) : radioControl;

  // only the six pipe bits take writes
  wire rcrb_byte_t next_autoackPipeReg =
    writeAutoack ? mergeWrite(autoackPipeReg, hostData, PIPE_WMASK) : autoackPipeReg;

  wire rcrb_byte_t next_rxPipeReg =
    writeRxPipes ? mergeWrite(rxPipeReg, hostData, PIPE_WMASK) : rxPipeReg;

  // the illegal code is stored as written; see width decode
  wire rcrb_byte_t next_addressWidthSetup = writeAddrWidth ?
    mergeWrite(addressWidthSetup, hostData, ADDR_WIDTH_WMASK) : addressWidthSetup;

  // delay and count share one byte
  wire rcrb_byte_t next_retransmitSetup = writeRetransmit ?
    mergeWrite(retransmitSetup, hostData, RETRANSMIT_WMASK) : retransmitSetup;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      radioControl <= CONTROL_RESET;
      autoackPipeReg <= AUTOACK_RESET;
      rxPipeReg <= RX_PIPE_RESET;
      addressWidthSetup <= ADDR_WIDTH_RESET;
      retransmitSetup <= RETRANSMIT_RESET;
    end
    else
    begin
      radioControl <= next_radioControl;
      autoackPipeReg <= next_autoackPipeReg;
      rxPipeReg <= next_rxPipeReg;
      addressWidthSetup <= next_addressWidthSetup;
      retransmitSetup <= next_retransmitSetup;
    end
  end

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  // set beats a same-cycle write-1 clear, so no event is lost
  wire next_receiveReadyFlag = receiveReadyEvent ||
    (receiveReadyFlag && !(writeStatus && hostData[RECEIVE_READY_FLAG_BIT]));

  wire next_transmitDoneFlag = transmitDoneEvent ||
    (transmitDoneFlag && !(writeStatus && hostData[TRANSMIT_DONE_FLAG_BIT]));

  wire next_retryLimitFlag = retryLimitEvent ||
    (retryLimitFlag && !(writeStatus && hostData[RETRY_LIMIT_FLAG_BIT]));

  // a mask bit of one keeps its flag off the line
  wire irqActive =
    (next_receiveReadyFlag && !radioControl[MASK_RECEIVE_READY_BIT]) ||
    (next_transmitDoneFlag && !radioControl[MASK_TRANSMIT_DONE_BIT]) ||
    (next_retryLimitFlag && !radioControl[MASK_RETRY_LIMIT_BIT]);

  // Registered line

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      receiveReadyFlag <= 1'b0;
      transmitDoneFlag <= 1'b0;
      retryLimitFlag <= 1'b0;
      radioIrqN <= 1'b1;
    end
    else
    begin
      receiveReadyFlag <= next_receiveReadyFlag;
      transmitDoneFlag <= next_transmitDoneFlag;
      retryLimitFlag <= next_retryLimitFlag;
      // line follows unmasked flags, active low
      radioIrqN <= !irqActive;
    end
  end

  // ---------------------------------------------------------------
  // Effective settings
  // ---------------------------------------------------------------
  // any auto-acknowledge pipe forces CRC on, in readback too
  wire anyAutoack = |autoackPipeReg[PIPE_COUNT-1:0];
  wire rcrb_byte_t controlView = radioControl | (anyAutoack ? (8'h01 << CRC_ENABLE_BIT) : 8'h00);

  wire [2:0] next_addrWidthBytes = widthBytes(addressWidthSetup[1:0]);
  wire [3:0] delayCode = retransmitSetup[RETRY_DELAY_MSB:RETRY_DELAY_LSB];
  wire [3:0] countCode = retransmitSetup[RETRY_COUNT_MSB:RETRY_COUNT_LSB];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // Reset images
      powerOnBit <= CONTROL_RESET[POWER_ON_BIT];
      receiverRoleSelect <= CONTROL_RESET[RECEIVER_ROLE_BIT];
      crcEnable <= 1'b1;
      crcLengthSelect <= CONTROL_RESET[CRC_LENGTH_BIT];
      autoackPipeEnables <= AUTOACK_RESET[PIPE_COUNT-1:0];
      rxPipeEnables <= RX_PIPE_RESET[PIPE_COUNT-1:0];
      addrWidthBytes <= widthBytes(ADDR_WIDTH_RESET[1:0]);
      addrByteUsed <= usedBytes(widthBytes(ADDR_WIDTH_RESET[1:0]));
      retryDelayCycles <= delayCycles(RETRANSMIT_RESET[RETRY_DELAY_MSB:RETRY_DELAY_LSB]);
      retryCountField <= RETRANSMIT_RESET[RETRY_COUNT_MSB:RETRY_COUNT_LSB];
      retransmitEnable <= 1'b1;
    end
    else
    begin
      powerOnBit <= radioControl[POWER_ON_BIT];
      receiverRoleSelect <= radioControl[RECEIVER_ROLE_BIT];
      crcEnable <= controlView[CRC_ENABLE_BIT];
      crcLengthSelect <= radioControl[CRC_LENGTH_BIT];
      autoackPipeEnables <= autoackPipeReg[PIPE_COUNT-1:0];
      rxPipeEnables <= rxPipeReg[PIPE_COUNT-1:0];
      addrWidthBytes <= next_addrWidthBytes;
      // low bytes of each address stay in use
      addrByteUsed <= usedBytes(next_addrWidthBytes);
      retryDelayCycles <= delayCycles(delayCode);
      retryCountField <= countCode;
      retransmitEnable <= (countCode != 4'h0);
    end
  end

  // ---------------------------------------------------------------
  // Read image for the serial end
  // ---------------------------------------------------------------
  // Frozen during a frame so the serial side reads stable bits;
  // a flag set mid-frame shows on the next frame only.
  rcrb_shadow_t shadow;
  rcrb_shadow_t next_shadow;

  // Unused slots zero
  always_comb
  begin
    next_shadow = '0;
    next_shadow[ADDR_RADIO_CONTROL[2:0]] = controlView;
    next_shadow[ADDR_AUTOACK_PIPE_ENABLES[2:0]] = autoackPipeReg;
    next_shadow[ADDR_RX_PIPE_ENABLES[2:0]] = rxPipeReg;
    next_shadow[ADDR_ADDRESS_WIDTH_SETUP[2:0]] = addressWidthSetup;
    next_shadow[ADDR_RETRANSMIT_SETUP[2:0]] = retransmitSetup;
    next_shadow[ADDR_STATUS[2:0]][RECEIVE_READY_FLAG_BIT] = receiveReadyFlag;
    next_shadow[ADDR_STATUS[2:0]][TRANSMIT_DONE_FLAG_BIT] = transmitDoneFlag;
    next_shadow[ADDR_STATUS[2:0]][RETRY_LIMIT_FLAG_BIT] = retryLimitFlag;
  end

  always_ff @(posedge clk)
  begin
    // host reads see the live registers between frames
    if (reset)
      shadow <= '0;
    else if (frameIdle)
      shadow <= next_shadow;
  end

  // Frozen copy only
  assign spiBus.shadow = shadow;

endmodule

/* File: src/rcrb_spi_if.sv */
// Carrier between the serial link end and the register bank end
`timescale 1ns/1ps
interface rcrb_spi_if;
  import rcrb_pkg::*;
  rcrb_shadow_t shadow;
  logic writeValid;
  rcrb_addr_t writeAddr;
  rcrb_byte_t writeData;

  modport link (input shadow, output writeValid, output writeAddr, output writeData);
  modport bank (output shadow, input writeValid, input writeAddr, input writeData);
endinterface

/* File: src/rcrb_spi_link.sv */
// Serial command shifter running on the host's serial clock
`timescale 1ns/1ps
module rcrb_spi_link
(
  input wire logic spiClk, // Serial clock from host, idles low
  input wire logic spiCsN, // Frame select, active low
  input wire logic spiMosi, // Serial data from host
  output logic spiMisoOut, // Serial data to host
  output logic spiMisoOe, // Drive enable for the data line
  rcrb_spi_if.link bus // Shadow in, write request out
);
  import rcrb_pkg::*;

  logic [2:0] bitCount;
  logic [1:0] byteCount;
  rcrb_byte_t rxShift;
  rcrb_byte_t command;
  rcrb_byte_t txShift;
  logic txLoaded;

  wire rcrb_byte_t rxByte = {rxShift[DATA_W-2:0], spiMosi};
  wire byteDone = (bitCount == BIT_LAST);
  wire isRead = (command[DATA_W-1:ADDR_W] == CMD_OP_READ);
  wire isWrite = (command[DATA_W-1:ADDR_W] == CMD_OP_WRITE);
  wire rcrb_addr_t cmdAddr = command[ADDR_W-1:0];
  wire cmdAddrMapped = (cmdAddr < rcrb_addr_t'(SHADOW_DEPTH));
  wire rcrb_byte_t statusByte = bus.shadow[ADDR_STATUS[2:0]];
  wire rcrb_byte_t readByte = cmdAddrMapped ? bus.shadow[cmdAddr[2:0]] : '0;
  wire firstDataWrite = byteDone && (byteCount == 2'h1) && isWrite;

  // ---------------------------------------------------------------
  // Receive side, sampled on rising edges
  // ---------------------------------------------------------------
  // Frame end clears state: no clock edge arrives after the last bit
  always_ff @(posedge spiClk or posedge spiCsN)
  begin
    if (spiCsN)
    begin
      bitCount <= '0;
      byteCount <= '0;
      rxShift <= '0;
      command <= '0;
      bus.writeValid <= 1'b0;
    end
    else
    begin
      bitCount <= bitCount + 3'h1;
      rxShift <= rxByte;
      if (byteDone && byteCount == 2'h0)
        command <= rxByte;
      if (firstDataWrite)
        bus.writeValid <= 1'b1;
      if (byteDone && byteCount != 2'h2)
        byteCount <= byteCount + 2'h1;
    end
  end

  // Held past frame end so the bank can sample it late
  always_ff @(posedge spiClk)
  begin
    if (firstDataWrite)
    begin
      bus.writeAddr <= cmdAddr;
      bus.writeData <= rxByte;
    end
  end

  // ---------------------------------------------------------------
  // Transmit side, changed on falling edges
  // ---------------------------------------------------------------
  always_ff @(negedge spiClk or posedge spiCsN)
  begin
    if (spiCsN)
    begin
      txShift <= '0;
      txLoaded <= 1'b0;
    end
    else if (bitCount == 3'h0)
    begin
      // register read data; unmapped reads zero
      txShift <= (byteCount == 2'h1 && isRead) ? readByte : '0;
    end
    else if (!txLoaded)
    begin
      txShift <= {statusByte[DATA_W-2:0], 1'b0};
      txLoaded <= 1'b1;
    end
    else
      txShift <= {txShift[DATA_W-2:0], 1'b0};
  end

  // First status bit must appear at select, before any clock edge
  assign spiMisoOut = txLoaded ? txShift[DATA_W-1] : statusByte[DATA_W-1];
  assign spiMisoOe = ~spiCsN;

endmodule
